// ==== common/aarc_pkg.sv ====
// aarc_pkg: command byte layout, reset values and mode codes for the
// averaging and reset command handling of the four-channel converter.
// assumes: nothing; shared by aarc_link and aarc_top (aarc_sync2 does not use it).
package aarc_pkg;

  // widths of the serial traffic and of the averaging sum
  localparam int BYTE_W      = 8;
  localparam int RES_W       = 10;
  localparam int FRAME_W     = 16;
  localparam int LEAD_ZEROS  = 4;
  localparam int TRAIL_ZEROS = 2;
  localparam int SUM_W       = 15;               // 32 results of 10 bits

  // command prefixes
  localparam logic       CONV_MARK    = 1'b1;    // bit 7
  localparam logic [1:0] SETUP_PREFIX = 2'h1;    // bits 7:6
  localparam logic [2:0] AVG_PREFIX   = 3'h1;    // bits 7:5
  localparam logic [3:0] RST_PREFIX   = 4'h1;    // bits 7:4

  // field positions
  localparam int CHAN_HI      = 4;
  localparam int CHAN_LO      = 3;
  localparam int SCAN_MODE_HI = 2;
  localparam int SCAN_MODE_LO = 1;
  localparam int CLK_MODE_HI  = 5;
  localparam int CLK_MODE_LO  = 4;
  localparam int AVG_EN_BIT   = 4;
  localparam int AVG_CNT_HI   = 3;
  localparam int AVG_CNT_LO   = 2;
  localparam int REP_CNT_HI   = 1;
  localparam int REP_CNT_LO   = 0;
  localparam int RST_KIND_BIT = 3;               // 1: fifo only, 0: everything

  // values after reset
  localparam logic       AVG_EN_RST    = 1'b0;
  localparam logic [1:0] AVG_SEL_RST   = 2'h0;
  localparam logic [1:0] REP_SEL_RST   = 2'h0;
  localparam logic [1:0] CLK_MODE_RST  = 2'h2;
  localparam logic [1:0] CHAN_RST      = 2'h0;
  localparam logic [1:0] SCAN_MODE_RST = 2'h0;

  // scan mode codes
  localparam logic [1:0] SCAN_UP     = 2'h0;
  localparam logic [1:0] SCAN_DOWN   = 2'h1;
  localparam logic [1:0] SCAN_REPEAT = 2'h2;
  localparam logic [1:0] SCAN_ONCE   = 2'h3;

  // clock mode codes
  localparam logic [1:0] CLK_PIN_INT = 2'h0;
  localparam logic [1:0] CLK_PIN_EXT = 2'h1;
  localparam logic [1:0] CLK_SERIAL  = 2'h3;

  // averaging and repeat counts
  localparam logic [2:0] AVG_BASE_SHIFT = 3'h2;  // 4 conversions = 1 << 2
  localparam logic [4:0] REP_STEP       = 5'h04; // 4, 8, 12, 16 results

  typedef enum logic [1:0] {
    AARC_IDLE = 2'b00,
    AARC_REQ  = 2'b01,
    AARC_WAIT = 2'b10
  } aarc_seq_t;

endpackage : aarc_pkg

// ==== src/aarc_sync2.sv ====
// aarc_sync2: two-stage synchroniser for a group of independent levels.
// assumes: each bit is a level or a toggle that holds for several clocks.
`timescale 1ns/1ps
module aarc_sync2 #(
  parameter int              WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } aarc_sync_t;

  aarc_sync_t st_ff;
  aarc_sync_t nxt_st;

  // first stage is read only by the second
  always_comb begin
    nxt_st = st_ff;
    if (srst) begin
      nxt_st.meta   = RST_VAL;
      nxt_st.stable = RST_VAL;
    end else if (ce) begin
      nxt_st.meta   = async_in;
      nxt_st.stable = st_ff.meta;
    end
  end

  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  assign sync_out = st_ff.stable;

endmodule : aarc_sync2

// ==== src/aarc_link.sv ====
// aarc_link: serial side on the master's clock; shifts command bytes in and
// result frames out.
// assumes: sclk runs only while cs_n is low; tx_word is stable around tx_tgl;
// srst is released while sclk stands still.
`timescale 1ns/1ps
module aarc_link (
  input  wire logic       sclk,
  input  wire logic       srst,
  input  wire logic       cs_n,
  input  wire logic       din,
  output logic            dout,
  output logic [7:0]      rx_hold0,
  output logic [7:0]      rx_hold1,
  output logic            rx_tgl,
  input  wire logic [9:0] tx_word,
  input  wire logic       tx_tgl,
  output logic            tx_ack_tgl
);

  // partial byte; cleared by cs_n so a cut frame leaves nothing behind
  typedef struct packed {
    logic [6:0] shift;
    logic [2:0] cnt;
  } aarc_rxb_t;

  // finished bytes and their toggle; only srst clears them
  typedef struct packed {
    logic [7:0] hold0;
    logic [7:0] hold1;
    logic       tgl;
  } aarc_rxh_t;

  // output slot position and shifter; cs_n parks the slot at 15 and empties the frame
  typedef struct packed {
    logic [3:0]  slot;
    logic [15:0] frame;
  } aarc_txs_t;

  // hand-off synchroniser and acknowledge; only srst clears them
  typedef struct packed {
    logic meta;
    logic stable;
    logic seen;
    logic ack;
  } aarc_txh_t;

  aarc_rxb_t rxb_ff;
  aarc_rxb_t nxt_rxb;
  aarc_rxh_t rxh_ff;
  aarc_rxh_t nxt_rxh;
  aarc_txs_t txs_ff;
  aarc_txs_t nxt_txs;
  aarc_txh_t txh_ff;
  aarc_txh_t nxt_txh;

  // byte assembly, msb first, sampled on rising sclk; alternate holding slots
  always_comb begin
    nxt_rxb       = rxb_ff;
    nxt_rxh       = rxh_ff;
    nxt_rxb.shift = {rxb_ff.shift[5:0], din};
    nxt_rxb.cnt   = rxb_ff.cnt + 3'h1;
    if (rxb_ff.cnt == 3'h7) begin
      if (rxh_ff.tgl) begin
        nxt_rxh.hold1 = {rxb_ff.shift, din};
      end else begin
        nxt_rxh.hold0 = {rxb_ff.shift, din};
      end
      nxt_rxh.tgl = ~rxh_ff.tgl;
    end
  end

  // the frame's own select ends a partial byte
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rxb_ff <= '0;
    end else begin
      rxb_ff <= nxt_rxb;
    end
  end

  // toggle must start equal to the mclk side's copy, hence srst here
  always_ff @(posedge sclk or posedge srst) begin
    if (srst) begin
      rxh_ff <= '0;
    end else begin
      rxh_ff <= nxt_rxh;
    end
  end

  // result frames shift out on falling sclk in sixteen-clock slots
  always_comb begin
    nxt_txs        = txs_ff;
    nxt_txh        = txh_ff;
    nxt_txh.meta   = tx_tgl;
    nxt_txh.stable = txh_ff.meta;
    nxt_txs.slot   = txs_ff.slot + 4'h1;
    nxt_txs.frame  = {txs_ff.frame[14:0], 1'b0};
    if (txs_ff.slot == 4'hf) begin
      nxt_txs.frame = '0;
      if (txh_ff.stable != txh_ff.seen) begin
        nxt_txs.frame = {{aarc_pkg::LEAD_ZEROS{1'b0}}, tx_word,
                         {aarc_pkg::TRAIL_ZEROS{1'b0}}};
        nxt_txh.seen  = txh_ff.stable;
        nxt_txh.ack   = ~txh_ff.ack;
      end
    end
  end

  // slot restarts with every select
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      txs_ff.slot  <= 4'hf;
      txs_ff.frame <= 16'h0000;
    end else begin
      txs_ff <= nxt_txs;
    end
  end

  // hand-off state survives deselect so no word is offered twice
  always_ff @(negedge sclk or posedge srst) begin
    if (srst) begin
      txh_ff <= '0;
    end else begin
      txh_ff <= nxt_txh;
    end
  end

  assign dout       = txs_ff.frame[15];
  assign rx_hold0   = rxh_ff.hold0;
  assign rx_hold1   = rxh_ff.hold1;
  assign rx_tgl     = rxh_ff.tgl;
  assign tx_ack_tgl = txh_ff.ack;

endmodule : aarc_link

// ==== src/aarc_top.sv ====
// aarc_top: command decode, averaging, repeated-scan sequencing, result
// fifo and reset commands of a four-channel converter's serial port.
// assumes: a converter core on mclk answers conv_start with one conv_done.
`timescale 1ns/1ps
module aarc_top #(
  parameter int NUM_CHAN   = 4,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       din,
  output logic            dout,
  input  wire logic       cnvst_n,
  output logic            conv_start,
  output logic [1:0]      conv_chan,
  input  wire logic       conv_done,
  input  wire logic [9:0] conv_data,
  output logic            averaging_enable,
  output logic [1:0]      clock_mode,
  output logic            scan_busy,
  output logic [4:0]      fifo_level
);

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam logic [1:0] LAST_CHAN = 2'(NUM_CHAN - 1);

  typedef struct packed {
    logic                              avg_en;
    logic [1:0]                        avg_sel;
    logic [1:0]                        rep_sel;
    logic [1:0]                        clk_mode;
    logic [1:0]                        chan_sel;
    logic [1:0]                        scan_mode;
    logic                              rx_seen;
    logic                              ack_seen;
    logic                              cnvst_prev;
    aarc_pkg::aarc_seq_t               seq;
    logic                              run_walk;
    logic [1:0]                        cur_chan;
    logic [4:0]                        res_left;
    logic [5:0]                        conv_left;
    logic [5:0]                        conv_per_res;
    logic [2:0]                        avg_shift;
    logic [aarc_pkg::SUM_W-1:0]        sum;
    logic [FIFO_DEPTH-1:0][9:0]        mem;
    logic [PW-1:0]                     wr_ptr;
    logic [PW-1:0]                     rd_ptr;
    logic [PW:0]                       cnt;
    logic [9:0]                        tx_word;
    logic                              tx_tgl;
    logic                              tx_busy;
    logic                              start;
    logic [1:0]                        chan_out;
  } aarc_st_t;

  aarc_st_t st_ff;
  aarc_st_t nxt_st;

  logic [7:0] rx_hold0;
  logic [7:0] rx_hold1;
  logic       rx_tgl_raw;
  logic       ack_tgl_raw;
  logic [2:0] synced;
  logic       rx_tgl_s;
  logic       ack_tgl_s;
  logic       cnvst_n_s;

  // link side on the master's clock
  aarc_link u_link (
    .sclk       (sclk),
    .srst       (srst),
    .cs_n       (cs_n),
    .din        (din),
    .dout       (dout),
    .rx_hold0   (rx_hold0),
    .rx_hold1   (rx_hold1),
    .rx_tgl     (rx_tgl_raw),
    .tx_word    (st_ff.tx_word),
    .tx_tgl     (st_ff.tx_tgl),
    .tx_ack_tgl (ack_tgl_raw)
  );

  // toggles from the link and the start pin cross into mclk
  aarc_sync2 #(
    .WIDTH   (3),
    .RST_VAL (3'h4)
  ) u_sync (
    .mclk     (mclk),
    .srst     (srst),
    .ce       (ce),
    .async_in ({cnvst_n, ack_tgl_raw, rx_tgl_raw}),
    .sync_out (synced)
  );

  assign rx_tgl_s  = synced[0];
  assign ack_tgl_s = synced[1];
  assign cnvst_n_s = synced[2];

  // next state: decode, sequencing, fifo and hand-off to the link
  always_comb begin
    logic [7:0]               cmd;
    logic                     new_byte;
    logic                     go;
    logic [aarc_pkg::SUM_W-1:0] total;
    logic                     push;
    logic [9:0]               push_val;
    logic                     pop;
    logic                     clr_fifo;
    logic                     clr_all;
    cmd      = st_ff.rx_seen ? rx_hold1 : rx_hold0;
    new_byte = (rx_tgl_s != st_ff.rx_seen);
    go       = 1'b0;
    total    = '0;
    push     = 1'b0;
    push_val = '0;
    pop      = 1'b0;
    clr_fifo = 1'b0;
    clr_all  = 1'b0;
    nxt_st   = st_ff;
    nxt_st.start      = 1'b0;
    nxt_st.cnvst_prev = cnvst_n_s;
    if (new_byte) begin
      nxt_st.rx_seen = rx_tgl_s;
      if (cmd[7] == aarc_pkg::CONV_MARK) begin
        nxt_st.chan_sel  = cmd[aarc_pkg::CHAN_HI:aarc_pkg::CHAN_LO];
        nxt_st.scan_mode = cmd[aarc_pkg::SCAN_MODE_HI:aarc_pkg::SCAN_MODE_LO];
        go = st_ff.clk_mode[1];                   // serial start in modes 10, 11
      end else if (cmd[7:6] == aarc_pkg::SETUP_PREFIX) begin
        nxt_st.clk_mode = cmd[aarc_pkg::CLK_MODE_HI:aarc_pkg::CLK_MODE_LO];
      end else if (cmd[7:5] == aarc_pkg::AVG_PREFIX) begin
        nxt_st.avg_en  = cmd[aarc_pkg::AVG_EN_BIT];
        nxt_st.avg_sel = cmd[aarc_pkg::AVG_CNT_HI:aarc_pkg::AVG_CNT_LO];
        nxt_st.rep_sel = cmd[aarc_pkg::REP_CNT_HI:aarc_pkg::REP_CNT_LO];
      end else if (cmd[7:4] == aarc_pkg::RST_PREFIX) begin
        clr_fifo = 1'b1;
        clr_all  = ~cmd[aarc_pkg::RST_KIND_BIT];
      end
    end
    // pin start in clock modes 00 and 01 on a falling edge
    if (!st_ff.clk_mode[1] && st_ff.cnvst_prev && !cnvst_n_s) begin
      go = 1'b1;
    end
    case (st_ff.seq)
      aarc_pkg::AARC_IDLE: begin
        if (go) begin
          // settings are latched here, so later writes wait for the next scan
          nxt_st.seq       = aarc_pkg::AARC_REQ;
          nxt_st.sum       = '0;
          nxt_st.run_walk  = 1'b0;
          nxt_st.cur_chan  = nxt_st.chan_sel;
          nxt_st.res_left  = 5'h01;
          nxt_st.avg_shift = 3'h0;
          nxt_st.conv_per_res = 6'h01;
          if (nxt_st.avg_en && st_ff.clk_mode != aarc_pkg::CLK_SERIAL) begin
            nxt_st.avg_shift    = aarc_pkg::AVG_BASE_SHIFT + {1'b0, nxt_st.avg_sel};
            nxt_st.conv_per_res = 6'h01 << nxt_st.avg_shift;
          end
          if (st_ff.clk_mode != aarc_pkg::CLK_SERIAL) begin
            case (nxt_st.scan_mode)
              aarc_pkg::SCAN_UP: begin
                nxt_st.cur_chan = 2'h0;
                nxt_st.res_left = {3'h0, nxt_st.chan_sel} + 5'h01;
                nxt_st.run_walk = 1'b1;
              end
              aarc_pkg::SCAN_DOWN: begin
                nxt_st.res_left = {3'h0, LAST_CHAN} - {3'h0, nxt_st.chan_sel} + 5'h01;
                nxt_st.run_walk = 1'b1;
              end
              aarc_pkg::SCAN_REPEAT: begin
                nxt_st.res_left = aarc_pkg::REP_STEP * ({3'h0, nxt_st.rep_sel} + 5'h01);
              end
              default: begin
                nxt_st.res_left = 5'h01;
              end
            endcase
          end
          nxt_st.conv_left = nxt_st.conv_per_res;
        end
      end
      aarc_pkg::AARC_REQ: begin
        nxt_st.start    = 1'b1;
        nxt_st.chan_out = st_ff.cur_chan;
        nxt_st.seq      = aarc_pkg::AARC_WAIT;
      end
      aarc_pkg::AARC_WAIT: begin
        if (conv_done) begin
          total     = st_ff.sum + {5'h00, conv_data};
          nxt_st.sum       = total;
          nxt_st.conv_left = st_ff.conv_left - 6'h01;
          nxt_st.seq       = aarc_pkg::AARC_REQ;
          if (st_ff.conv_left == 6'h01) begin
            push     = 1'b1;
            push_val = 10'(total >> st_ff.avg_shift);
            nxt_st.sum       = '0;
            nxt_st.conv_left = st_ff.conv_per_res;
            nxt_st.res_left  = st_ff.res_left - 5'h01;
            if (st_ff.run_walk) begin
              nxt_st.cur_chan = st_ff.cur_chan + 2'h1;
            end
            if (st_ff.res_left == 5'h01) begin
              nxt_st.seq = aarc_pkg::AARC_IDLE;
            end
          end
        end
      end
      default: begin
        nxt_st.seq = aarc_pkg::AARC_IDLE;
      end
    endcase
    // link finished taking the word it was offered
    if (ack_tgl_s != st_ff.ack_seen) begin
      nxt_st.ack_seen = ack_tgl_s;
      nxt_st.tx_busy  = 1'b0;
    end
    // offer the oldest result to the link
    if (!st_ff.tx_busy && st_ff.cnt != '0) begin
      pop            = 1'b1;
      nxt_st.tx_word = st_ff.mem[st_ff.rd_ptr];
      nxt_st.tx_tgl  = ~st_ff.tx_tgl;
      nxt_st.tx_busy = 1'b1;
      nxt_st.rd_ptr  = st_ff.rd_ptr + PW'(1);
    end
    // store a finished result; a full fifo drops it
    if (push && st_ff.cnt != (PW+1)'(FIFO_DEPTH)) begin
      nxt_st.mem[st_ff.wr_ptr] = push_val;
      nxt_st.wr_ptr = st_ff.wr_ptr + PW'(1);
    end
    nxt_st.cnt = st_ff.cnt + (PW+1)'(push && st_ff.cnt != (PW+1)'(FIFO_DEPTH))
                 - (PW+1)'(pop);
    // reset commands override whatever moved the fifo this cycle
    if (clr_fifo) begin
      nxt_st.wr_ptr = '0;
      nxt_st.rd_ptr = '0;
      nxt_st.cnt    = '0;
    end
    if (clr_all) begin
      nxt_st.avg_en    = aarc_pkg::AVG_EN_RST;
      nxt_st.avg_sel   = aarc_pkg::AVG_SEL_RST;
      nxt_st.rep_sel   = aarc_pkg::REP_SEL_RST;
      nxt_st.clk_mode  = aarc_pkg::CLK_MODE_RST;
      nxt_st.chan_sel  = aarc_pkg::CHAN_RST;
      nxt_st.scan_mode = aarc_pkg::SCAN_MODE_RST;
      nxt_st.seq       = aarc_pkg::AARC_IDLE;
      nxt_st.start     = 1'b0;
    end
  end

  // state register: synchronous reset, frozen while ce is low
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ff           <= '0;
      st_ff.avg_en    <= aarc_pkg::AVG_EN_RST;
      st_ff.avg_sel   <= aarc_pkg::AVG_SEL_RST;
      st_ff.rep_sel   <= aarc_pkg::REP_SEL_RST;
      st_ff.clk_mode  <= aarc_pkg::CLK_MODE_RST;
      st_ff.chan_sel  <= aarc_pkg::CHAN_RST;
      st_ff.scan_mode <= aarc_pkg::SCAN_MODE_RST;
      st_ff.cnvst_prev <= 1'b1;
      st_ff.seq       <= aarc_pkg::AARC_IDLE;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // status and converter outputs, all from flops
  assign conv_start       = st_ff.start;
  assign conv_chan        = st_ff.chan_out;
  assign averaging_enable = st_ff.avg_en;
  assign clock_mode       = st_ff.clk_mode;
  assign scan_busy        = (st_ff.seq != aarc_pkg::AARC_IDLE);
  assign fifo_level       = 5'(st_ff.cnt);

endmodule : aarc_top

// ==== tb/aarc_top_chk.sv ====
// aarc_top_chk: port-level checks of the averaging and reset command block.
// assumes: bound to aarc_top; everything here is on mclk.
`timescale 1ns/1ps
module aarc_top_chk #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       conv_start,
  input wire logic [1:0] conv_chan,
  input wire logic       conv_done,
  input wire logic       scan_busy,
  input wire logic [4:0] fifo_level,
  input wire logic       averaging_enable,
  input wire logic [1:0] clock_mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // first request after the sequencer leaves idle
  sequence s_req;
    ##[1:2] conv_start;
  endsequence
  // no further conversion request for eight cycles
  sequence s_quiet;
    !conv_start [*8];
  endsequence
  conv_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("conversion request longer than one cycle");
  busy_req_a: assert property (conv_start |-> scan_busy)
    else $error("conversion request while sequencer idle");
  start_lat_a: assert property ($rose(scan_busy) |-> s_req)
    else $error("no conversion request after scan start");
  next_conv_a: assert property (conv_done && scan_busy |-> ##[1:3] (conv_start || !scan_busy))
    else $error("sequencer stalled after a conversion");
  chan_hold_a: assert property (scan_busy && $past(scan_busy) && !conv_start
    |-> $stable(conv_chan))
    else $error("channel moved between requests");
  ext_single_a: assert property (clock_mode == 2'h3 && conv_start |=> s_quiet)
    else $error("more than one conversion in clock mode 11");
  reset_vals_a: assert property ($past(srst) |-> !averaging_enable && clock_mode == 2'h2
    && fifo_level == 5'h0)
    else $error("wrong values after reset");
  fifo_step_a: assert property (!$stable(fifo_level) |-> fifo_level == 5'h0
    || fifo_level == $past(fifo_level) + 5'h1 || fifo_level + 5'h1 == $past(fifo_level))
    else $error("result count jumped");
  fifo_max_a: assert property (fifo_level <= FIFO_DEPTH)
    else $error("result count above depth");
endmodule : aarc_top_chk

// ==== tb/aarc_master.sv ====
// aarc_master: behavioural serial master driving command bytes and reading frames.
// assumes: sclk idles low and runs only while cs_n is low.
`timescale 1ns/1ps
module aarc_master (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // one frame: nbits of tx msb first (zeros above bit 31), dout sampled on
  // each rising sclk; rx keeps the last 32 bits
  task automatic frame(input logic [31:0] tx, input int nbits, input bit slow,
                       output logic [31:0] rx);
    int      i;
    realtime h;
    h = slow ? 105.0 : 16.0;
    rx = '0;
    cs_n = 1'b0;
    for (i = nbits - 1; i >= 0; i--) begin
      din = (i < 32) ? tx[i] : 1'b0;
      #(h) sclk = 1'b1;
      rx = {rx[30:0], dout};
      #(h) sclk = 1'b0;
    end
    #(h) cs_n = 1'b1;
    din = ~din;
    #(h);
  endtask : frame
endmodule : aarc_master

// ==== tb/test_adc_averaging_reset_control.sv ====
// test_adc_averaging_reset_control: directed checks of command decode and scans.
// assumes: aarc_top, aarc_master and aarc_top_chk compiled before this file.
`timescale 1ns/1ps
module test_adc_averaging_reset_control;
  logic        mclk, srst, ce, cnvst_n, conv_done;
  logic [9:0]  conv_data;
  logic        sclk, cs_n, din, dout, conv_start, averaging_enable, scan_busy;
  logic [1:0]  conv_chan, clock_mode;
  logic [4:0]  fifo_level;
  logic [31:0] rx;
  int          n_fail, num_checks, n_conv, wait_c, s;
  bit          slow;
  aarc_top dut_u (.mclk(mclk), .srst(srst), .ce(ce), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .cnvst_n(cnvst_n), .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_done(conv_done), .conv_data(conv_data), .averaging_enable(averaging_enable),
    .clock_mode(clock_mode), .scan_busy(scan_busy), .fifo_level(fifo_level));
  aarc_master mst_u (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // converter core: answers each request 3 cycles later, values alternate by 2
  always @(posedge mclk) begin
    if (conv_start === 1'b1) begin
      n_conv++;
      wait_c = 3;
    end else if (wait_c > 0) begin
      wait_c--;
    end
    #2 conv_done = (wait_c == 1);
    conv_data = 10'h2a0 + {n_conv[0], 1'b0};
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task end_of_test;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  task tick;
    @(posedge mclk);
    #2;
  endtask : tick
  // one command byte, then time for it to cross into mclk
  task wr(input logic [7:0] b);
    mst_u.frame({24'h0, b}, 8, slow, rx);
    repeat (10) tick();
  endtask : wr
  // start a scan and count the conversions it asks for
  task run_scan(input logic [7:0] b, input int exp_n);
    int i;
    n_conv = 0;
    // a zero byte stands for a start pulse on cnvst_n
    if (b == 8'h00) begin
      cnvst_n = 1'b0;
      repeat (3) tick();
      cnvst_n = 1'b1;
    end else begin
      mst_u.frame({24'h0, b}, 8, slow, rx);
    end
    for (i = 0; i < 20 && scan_busy !== 1'b1; i++) tick();
    if (i == 20) begin
      n_fail++;
      end_of_test();
    end
    for (i = 0; i < 3000 && scan_busy !== 1'b0; i++) tick();
    if (i == 3000) begin
      n_fail++;
      end_of_test();
    end
    repeat (8) tick();
    chk(n_conv, exp_n);
  endtask : run_scan
  initial begin
    {srst, ce, cnvst_n, conv_done, conv_data, slow, n_fail, num_checks} = '0;
    ce = 1'b1;
    cnvst_n = 1'b1;
    // a real rising edge, so the link's own reset sees it
    #2 srst = 1'b1;
    repeat (6) @(posedge mclk);
    #2 srst = 1'b0;
    tick();
    chk(clock_mode, 2'h2);
    chk(averaging_enable, 1'b0);
    $display("test reset values done");
    wr(8'h34);
    chk(averaging_enable, 1'b1);
    run_scan(8'h8e, 8);
    chk(conv_chan, 2'h1);
    // results move on falling sclk, so the first rise after select holds no slot bit
    mst_u.frame(32'h0, 33, slow, rx);
    chk(rx[31:16], 16'h0);
    chk(rx[15:0], {4'h0, 10'h2a1, 2'h0});
    $display("test averaged frame done");
    for (s = 0; s < 4; s++) begin
      wr(8'(8'h30 | (s << 2)));
      run_scan(8'h8e, 4 << s);
    end
    wr(8'h2c);
    chk(averaging_enable, 1'b0);
    run_scan(8'h8e, 1);
    $display("test averaging counts done");
    for (s = 0; s < 4; s++) begin
      wr(8'(8'h20 | s));
      run_scan(8'h94, 4 * (s + 1));
    end
    $display("test repeat counts done");
    wr(8'h33);
    run_scan(8'h98, 16);
    run_scan(8'h92, 8);
    $display("test scan modes done");
    wr(8'h70);
    chk(clock_mode, 2'h3);
    slow = 1'b1;
    run_scan(8'h8e, 1);
    $display("test external clock mode done");
    chk(fifo_level != 5'h0, 1'b1);
    wr(8'h18);
    chk(fifo_level, 5'h0);
    chk(averaging_enable, 1'b1);
    chk(clock_mode, 2'h3);
    wr(8'h10);
    chk(averaging_enable, 1'b0);
    chk(clock_mode, 2'h2);
    $display("test reset commands done");
    // back in clock mode 10, so the fast serial clock is allowed again
    slow = 1'b0;
    wr(8'h40);
    chk(clock_mode, 2'h0);
    wr(8'h30);
    run_scan(8'h00, 4);
    chk(conv_chan, 2'h0);
    $display("test pin start done");
    end_of_test();
  end
endmodule : test_adc_averaging_reset_control
bind aarc_top aarc_top_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.mclk(mclk), .srst(srst),
  .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done),
  .scan_busy(scan_busy), .fifo_level(fifo_level), .averaging_enable(averaging_enable),
  .clock_mode(clock_mode));
